//--- src/bwd_ctrl.sv
// Window decode and bridge control registers of a multi-port bridge.
// Assumes a configuration port with dword offsets and byte enables,
// and lower window bounds supplied by neighbouring registers.
//
// Contract
// - Prefetch limit upper dword, writable, forwarding.
// - I/O base upper half, writable, forwarding.
// - I/O limit upper half, writable, forwarding.
// - Capability pointer reads constant b0.
// - Bit 16 gates secondary parity detection.
// - Bit 17 gates secondary error forwarding upstream.
// - Bit 18 clear forwards whole I/O window.
// - Bit 18 blocks alias addresses going downstream.
// - Bit 18 sends alias addresses upstream.
// - Prefetch limit low twenty bits read ones.
// - Secondary error sets sticky flag, write-one clears.
`timescale 1ns/1ps
module bwd_ctrl
   import bwd_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Configuration access from the primary side.
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   // Lower window bounds from neighbouring registers.
   input wire logic [63:20] pf_base_i,
   input wire logic [31:20] pf_limit_lo_i,
   input wire logic [15:12] io_base_lo_i,
   input wire logic [15:12] io_limit_lo_i,
   // Primary side request to be decoded for downstream forwarding.
   input wire logic pri_valid_i,
   input wire logic pri_is_io_i,
   input wire logic [63:0] pri_addr_i,
   output logic down_fwd_o,
   output logic down_done_o,
   // Secondary side request to be decoded for upstream forwarding.
   input wire logic sec_valid_i,
   input wire logic sec_is_io_i,
   input wire logic [63:0] sec_addr_i,
   output logic up_fwd_o,
   output logic up_done_o,
   // Secondary error pins and parity error events.
   input wire logic sec_a_error_pin_n_i,
   input wire logic sec_b_error_pin_n_i,
   input wire logic sec_par_err_i,
   output logic pri_error_req_o,
   output logic sec_par_report_o
);
   // ****************************************************************
   // Reset release.
   // ****************************************************************
   logic rst_meta_ff; // First stage, read only by the second.
   logic rst_n_ff; // Released reset used by the whole block.

   // Assert at once, release after two clean edges.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // ****************************************************************
   // Register state.
   // ****************************************************************
   logic [31:0] pf_limit_high_ff, nxt_pf_limit_high; // Top address 63:32.
   logic [15:0] io_base_high_ff, nxt_io_base_high; // Bottom I/O 31:16.
   logic [15:0] io_limit_high_ff, nxt_io_limit_high; // Top I/O 31:16.
   logic par_resp_ff, nxt_par_resp; // Secondary parity response.
   logic serr_fwd_ff, nxt_serr_fwd; // Secondary error forwarding.
   logic isa_en_ff, nxt_isa_en; // ISA alias blocking.
   logic rx_serr_ff, nxt_rx_serr; // Sticky received system error.
   logic det_perr_ff, nxt_det_perr; // Sticky detected parity error.
   logic [31:0] rdata_ff, nxt_rdata; // Read data holding register.
   logic sec_err_any; // Either secondary error pin is low.
   logic [7:0] cfg_dw; // Dword aligned offset.

   // Merge write data into an old value under byte enables.
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : be_merge

   // ****************************************************************
   // Register next state.
   // ****************************************************************
   // Writes land in the dword named by the offset; sticky flags let a
   // new event win over a write-one clear in the same cycle so that no
   // error is lost while software is acknowledging the previous one.
   always_comb begin
      logic [31:0] mrg;
      mrg = 32'h0000_0000;
      cfg_dw = {cfg_addr_i[7:2], 2'h0};
      sec_err_any = !sec_a_error_pin_n_i || !sec_b_error_pin_n_i;
      nxt_pf_limit_high = pf_limit_high_ff;
      nxt_io_base_high = io_base_high_ff;
      nxt_io_limit_high = io_limit_high_ff;
      nxt_par_resp = par_resp_ff;
      nxt_serr_fwd = serr_fwd_ff;
      nxt_isa_en = isa_en_ff;
      nxt_rx_serr = rx_serr_ff;
      nxt_det_perr = det_perr_ff;
      nxt_rdata = rdata_ff;
      if (cfg_wr_i) begin
         unique case (cfg_dw)
            OFS_PF_LIMIT_HIGH: begin
               nxt_pf_limit_high = be_merge(pf_limit_high_ff, cfg_wdata_i, cfg_be_i);
            end
            OFS_IO_HIGH: begin
               mrg = be_merge({io_limit_high_ff, io_base_high_ff}, cfg_wdata_i, cfg_be_i);
               nxt_io_base_high = mrg[15:0];
               nxt_io_limit_high = mrg[31:16];
            end
            OFS_BRIDGE_CTRL: begin
               // Control bits all sit in byte lane two.
               if (cfg_be_i[2]) begin
                  nxt_par_resp = cfg_wdata_i[BIT_PAR_RESP];
                  nxt_serr_fwd = cfg_wdata_i[BIT_SERR_FWD];
                  nxt_isa_en = cfg_wdata_i[BIT_ISA_EN];
               end
            end
            OFS_SEC_STATUS: begin
               // Write one to clear, byte lane three only.
               if (cfg_be_i[3] && cfg_wdata_i[BIT_RX_SERR]) begin
                  nxt_rx_serr = 1'b0;
               end
               if (cfg_be_i[3] && cfg_wdata_i[BIT_DET_PERR]) begin
                  nxt_det_perr = 1'b0;
               end
            end
            default: begin
               // Other offsets belong elsewhere; writes are ignored.
            end
         endcase
      end
      if (sec_err_any) begin
         nxt_rx_serr = 1'b1;
      end
      if (sec_par_err_i && par_resp_ff) begin
         nxt_det_perr = 1'b1;
      end
      // Read data is captured on the read strobe and then held.
      if (cfg_rd_i) begin
         unique case (cfg_dw)
            OFS_PF_LIMIT_HIGH: nxt_rdata = pf_limit_high_ff;
            OFS_IO_HIGH: nxt_rdata = {io_limit_high_ff, io_base_high_ff};
            OFS_CAP_PTR: begin
               nxt_rdata = {24'h00_0000, CAP_LIST_PTR};
            end
            OFS_BRIDGE_CTRL: begin
               nxt_rdata = 32'h0000_0000;
               nxt_rdata[BIT_PAR_RESP] = par_resp_ff;
               nxt_rdata[BIT_SERR_FWD] = serr_fwd_ff;
               nxt_rdata[BIT_ISA_EN] = isa_en_ff;
            end
            OFS_SEC_STATUS: begin
               nxt_rdata = 32'h0000_0000;
               nxt_rdata[BIT_RX_SERR] = rx_serr_ff;
               nxt_rdata[BIT_DET_PERR] = det_perr_ff;
            end
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Register the configuration state.
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pf_limit_high_ff <= PF_LIMIT_HIGH_RST;
         io_base_high_ff <= IO_HIGH_RST;
         io_limit_high_ff <= IO_HIGH_RST;
         {isa_en_ff, serr_fwd_ff, par_resp_ff} <= BCTL_RST;
         rx_serr_ff <= 1'b0;
         det_perr_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         pf_limit_high_ff <= nxt_pf_limit_high;
         io_base_high_ff <= nxt_io_base_high;
         io_limit_high_ff <= nxt_io_limit_high;
         par_resp_ff <= nxt_par_resp;
         serr_fwd_ff <= nxt_serr_fwd;
         isa_en_ff <= nxt_isa_en;
         rx_serr_ff <= nxt_rx_serr;
         det_perr_ff <= nxt_det_perr;
         rdata_ff <= nxt_rdata;
      end
   end

   assign cfg_rdata_o = rdata_ff;

   // ****************************************************************
   // Window compares.
   // ****************************************************************
   // One comparator pair per direction; the window bounds are shared.
   bwd_win_if #(.W(W_PF)) pf_dn ();
   bwd_win_if #(.W(W_PF)) pf_up ();
   bwd_win_if #(.W(W_IO)) io_dn ();
   bwd_win_if #(.W(W_IO)) io_up ();

   // Assemble the full window bounds from the register fields.
   always_comb begin
      pf_dn.limit = {pf_limit_high_ff, pf_limit_lo_i, PF_LIMIT_LOW_ONES};
      pf_dn.base = {pf_base_i, 20'h00000};
      pf_dn.addr = pri_addr_i;
      pf_up.limit = pf_dn.limit;
      pf_up.base = pf_dn.base;
      pf_up.addr = sec_addr_i;
      io_dn.base = {io_base_high_ff, io_base_lo_i, 12'h000};
      io_dn.limit = {io_limit_high_ff, io_limit_lo_i, IO_LIMIT_LOW_ONES};
      io_dn.addr = pri_addr_i[31:0];
      io_up.base = io_dn.base;
      io_up.limit = io_dn.limit;
      io_up.addr = sec_addr_i[31:0];
   end

   bwd_win_cmp u_pf_dn (.win(pf_dn.cmp));
   bwd_win_cmp u_pf_up (.win(pf_up.cmp));
   bwd_win_cmp u_io_dn (.win(io_dn.cmp));
   bwd_win_cmp u_io_up (.win(io_up.cmp));

   // ****************************************************************
   // Forwarding decisions.
   // ****************************************************************
   logic down_fwd_ff, nxt_down_fwd; // Registered downstream decision.
   logic down_done_ff, nxt_down_done; // Decision valid pulse.
   logic up_fwd_ff, nxt_up_fwd; // Registered upstream decision.
   logic up_done_ff, nxt_up_done; // Decision valid pulse.
   logic err_req_ff, nxt_err_req; // Forwarded secondary error.
   logic perr_rep_ff, nxt_perr_rep; // Parity report pulse.
   logic alias_dn, alias_up; // Address is an ISA alias in first 64KB.

   // Upper three quarters of each 1KB block in the first 64KB are aliases.
   // The alias test applies only inside the window, so outside it the
   // normal inverse decode decides alone.
   always_comb begin
      alias_dn = (pri_addr_i[31:16] == IO_FIRST_64K_HI)
                 && (pri_addr_i[9:8] != ISA_LOW_QUARTER);
      alias_up = (sec_addr_i[31:16] == IO_FIRST_64K_HI)
                 && (sec_addr_i[9:8] != ISA_LOW_QUARTER);
      nxt_down_done = pri_valid_i;
      nxt_up_done = sec_valid_i;
      nxt_down_fwd = 1'b0;
      nxt_up_fwd = 1'b0;
      if (pri_valid_i) begin
         if (pri_is_io_i) begin
            nxt_down_fwd = io_dn.hit && !(isa_en_ff && alias_dn);
         end else begin
            nxt_down_fwd = pf_dn.hit;
         end
      end
      if (sec_valid_i) begin
         if (sec_is_io_i) begin
            nxt_up_fwd = !io_up.hit || (isa_en_ff && alias_up);
         end else begin
            nxt_up_fwd = !pf_up.hit;
         end
      end
      nxt_err_req = serr_fwd_ff && sec_err_any;
      nxt_perr_rep = par_resp_ff && sec_par_err_i;
   end

   // Register the decisions so every data output comes from a flop.
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         down_fwd_ff <= 1'b0;
         down_done_ff <= 1'b0;
         up_fwd_ff <= 1'b0;
         up_done_ff <= 1'b0;
         err_req_ff <= 1'b0;
         perr_rep_ff <= 1'b0;
      end else begin
         down_fwd_ff <= nxt_down_fwd;
         down_done_ff <= nxt_down_done;
         up_fwd_ff <= nxt_up_fwd;
         up_done_ff <= nxt_up_done;
         err_req_ff <= nxt_err_req;
         perr_rep_ff <= nxt_perr_rep;
      end
   end

   assign down_fwd_o = down_fwd_ff;
   assign down_done_o = down_done_ff;
   assign up_fwd_o = up_fwd_ff;
   assign up_done_o = up_done_ff;
   assign pri_error_req_o = err_req_ff;
   assign sec_par_report_o = perr_rep_ff;
endmodule : bwd_ctrl

//--- pkg/bwd_pkg.sv
// Constants shared by the bridge window decode block and its helpers.
// Assumes configuration offsets are byte addresses of aligned dwords.
package bwd_pkg;
   // ****************************************************************
   // Configuration offsets.
   // ****************************************************************
   localparam logic [7:0] OFS_SEC_STATUS = 8'h1c;
   localparam logic [7:0] OFS_PF_LIMIT_HIGH = 8'h2c;
   localparam logic [7:0] OFS_IO_HIGH = 8'h30;
   localparam logic [7:0] OFS_CAP_PTR = 8'h34;
   localparam logic [7:0] OFS_BRIDGE_CTRL = 8'h3c;
   // ****************************************************************
   // Field positions and constant values.
   // ****************************************************************
   localparam int BIT_PAR_RESP = 16;
   localparam int BIT_SERR_FWD = 17;
   localparam int BIT_ISA_EN = 18;
   localparam int BIT_RX_SERR = 30;
   localparam int BIT_DET_PERR = 31;
   localparam logic [7:0] CAP_LIST_PTR = 8'hb0;
   localparam logic [31:0] PF_LIMIT_HIGH_RST = 32'h0000_0000;
   localparam logic [15:0] IO_HIGH_RST = 16'h0000;
   localparam logic [2:0] BCTL_RST = 3'h0;
   localparam logic [19:0] PF_LIMIT_LOW_ONES = 20'hfffff;
   localparam logic [11:0] IO_LIMIT_LOW_ONES = 12'hfff;
   localparam int W_PF = 64;
   localparam int W_IO = 32;
   // Upper I/O bits that must be zero for the first 64KB.
   localparam logic [15:0] IO_FIRST_64K_HI = 16'h0000;
   // Bits 9:8 of zero mark the first 256 bytes of each 1KB block.
   localparam logic [1:0] ISA_LOW_QUARTER = 2'h0;
endpackage : bwd_pkg

//--- pkg/bwd_win_if.sv
// Carrier for one address window compare between the top and the comparator.
// Assumes base, limit and address are already assembled to full width.
`timescale 1ns/1ps
interface bwd_win_if #(parameter int W = 32);
   // Assembled window bottom, top and the address under test.
   logic [W-1:0] base;
   logic [W-1:0] limit;
   logic [W-1:0] addr;
   // High when addr lies inside the window.
   logic hit;
   modport owner (output base, output limit, output addr, input hit);
   modport cmp (input base, input limit, input addr, output hit);
endinterface : bwd_win_if

//--- src/bwd_win_cmp.sv
// Inclusive window comparator used for the I/O and prefetchable windows.
// Assumes the owner drives stable assembled bounds; purely combinational.
`timescale 1ns/1ps
module bwd_win_cmp
   import bwd_pkg::*;
(
   // Window carrier.
   bwd_win_if.cmp win
);
   // ****************************************************************
   // Compare.
   // ****************************************************************
   // Both bounds are inclusive, so a window of base equal to limit
   // still claims one granule; an inverted window claims nothing.
   always_comb begin
      win.hit = (win.addr >= win.base) && (win.addr <= win.limit);
   end
endmodule : bwd_win_cmp

//--- dv/bwd_ctrl_properties.sv
// Port-level checks on the window decode and bridge control block.
// Assumes inputs change away from the rising clock edge.
`timescale 1ns/1ps
module bwd_ctrl_chk (
   // Clock, reset and configuration port.
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [31:0] cfg_rdata_o,
   // Decode requests and answers.
   input wire logic pri_valid_i,
   input wire logic pri_is_io_i,
   input wire logic [63:0] pri_addr_i,
   input wire logic down_fwd_o,
   input wire logic down_done_o,
   input wire logic sec_valid_i,
   input wire logic sec_is_io_i,
   input wire logic [63:0] sec_addr_i,
   input wire logic up_fwd_o,
   input wire logic up_done_o,
   // Error pins and reports.
   input wire logic sec_a_error_pin_n_i,
   input wire logic sec_b_error_pin_n_i,
   input wire logic sec_par_err_i,
   input wire logic pri_error_req_o,
   input wire logic sec_par_report_o
);
   // Copy of the reset release and of the three control bits.
   logic [1:0] run_ff;
   logic [1:0] nxt_run;
   logic [2:0] ctl_ff;
   logic [2:0] nxt_ctl;
   // Alias addresses sit in the first 64KB with bits 9:8 not zero.
   wire logic pri_alias = pri_is_io_i && ctl_ff[2] && pri_addr_i[31:16] == 16'h0
      && pri_addr_i[9:8] != 2'h0;
   wire logic sec_alias = sec_is_io_i && ctl_ff[2] && sec_addr_i[31:16] == 16'h0
      && sec_addr_i[9:8] != 2'h0;
   // Next values; only a write with lane 2 enabled moves the control bits.
   always_comb begin
      nxt_run = {run_ff[0], 1'b1};
      nxt_ctl = ctl_ff;
      if (cfg_wr_i && cfg_addr_i == 8'h3c && cfg_be_i[2]) begin
         nxt_ctl = cfg_wdata_i[18:16];
      end
   end
   // The design runs two edges after release, so checks wait as long.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         run_ff <= 2'h0;
         ctl_ff <= 3'h0;
      end else begin
         run_ff <= nxt_run;
         ctl_ff <= nxt_ctl;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!run_ff[1]);
   chk_cap_value: assert property (cfg_rd_i && cfg_addr_i == 8'h34 |=>
      cfg_rdata_o == 32'h0000_00b0) else $error("pointer read wrong");
   chk_ctl_read: assert property (cfg_rd_i && cfg_addr_i == 8'h3c |=>
      cfg_rdata_o == {13'h0, $past(ctl_ff), 16'h0}) else $error("control read wrong");
   chk_par_gate: assert property (
      sec_par_report_o == $past(sec_par_err_i && ctl_ff[0])) else $error("parity report wrong");
   chk_err_fwd: assert property (ctl_ff[1] && !(sec_a_error_pin_n_i && sec_b_error_pin_n_i) |=>
      pri_error_req_o) else $error("error not forwarded");
   chk_err_block: assert property (!ctl_ff[1] |=> !pri_error_req_o)
      else $error("error forwarded while off");
   chk_isa_down: assert property (pri_valid_i && pri_alias |=>
      down_done_o && !down_fwd_o) else $error("alias sent downstream");
   chk_isa_up: assert property (sec_valid_i && sec_alias |=>
      up_done_o && up_fwd_o) else $error("alias not sent upstream");
   chk_rx_flag: assert property (!sec_b_error_pin_n_i ##1 cfg_rd_i && cfg_addr_i == 8'h1c |=>
      cfg_rdata_o[30]) else $error("received error flag clear");
   chk_dec_pulse: assert property (down_done_o == $past(pri_valid_i)
      && up_done_o == $past(sec_valid_i)) else $error("decode answer late");
endmodule : bwd_ctrl_chk
bind bwd_ctrl bwd_ctrl_chk chk_u (.clk_i, .nrst_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i,
   .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .pri_valid_i, .pri_is_io_i, .pri_addr_i,
   .down_fwd_o, .down_done_o, .sec_valid_i, .sec_is_io_i, .sec_addr_i, .up_fwd_o,
   .up_done_o, .sec_a_error_pin_n_i, .sec_b_error_pin_n_i, .sec_par_err_i,
   .pri_error_req_o, .sec_par_report_o);

//--- dv/bwd_sec_agent.sv
// Model of the secondary bus agents: requests, error pins, parity events.
// Assumes tasks are called just after a falling clock edge.
`timescale 1ns/1ps
module bwd_sec_agent (
   // Clock.
   input wire logic clk_i,
   // Secondary request and error signals.
   output logic sec_valid_o,
   output logic sec_is_io_o,
   output logic [63:0] sec_addr_o,
   output logic sec_a_n_o,
   output logic sec_b_n_o,
   output logic par_o
);
   // Error pins are pulled up, so idle means high.
   initial begin
      {sec_valid_o, sec_is_io_o, par_o} = 3'h0;
      sec_addr_o = 64'h0;
      {sec_a_n_o, sec_b_n_o} = 2'h3;
   end
   // Present one request; it stands until the next call.
   task automatic req(input logic io, input logic [63:0] x);
      sec_valid_o = 1'b1;
      sec_is_io_o = io;
      sec_addr_o = x;
   endtask : req
   // A released address bus must not keep its last value.
   task automatic idle();
      sec_valid_o = 1'b0;
      sec_addr_o = ~sec_addr_o;
   endtask : idle
   // Hold one error pin low for n cycles.
   task automatic serr(input logic b, input int n);
      @(negedge clk_i);
      if (b) sec_b_n_o = 1'b0;
      else sec_a_n_o = 1'b0;
      repeat (n) @(negedge clk_i);
      {sec_a_n_o, sec_b_n_o} = 2'h3;
   endtask : serr
   // One-cycle parity error event.
   task automatic perr();
      @(negedge clk_i);
      par_o = 1'b1;
      @(negedge clk_i);
      par_o = 1'b0;
   endtask : perr
endmodule : bwd_sec_agent

//--- dv/bwd_ctrl_tb.sv
// Self-checking bench for the window decode block against a model.
// Assumes the secondary agent model and the bound checker.
`timescale 1ns/1ps
module bwd_ctrl_tb;
   import bwd_pkg::*;
   // ****************************************************************
   // Stimulus, model state and counters.
   // ****************************************************************
   logic clk_i = 1'b0, nrst_i = 1'b0, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
   logic [7:0] cfg_addr_i = 8'h00;
   logic [3:0] cfg_be_i = 4'h0;
   logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o, e_rd, m_pfh, m_io;
   logic [63:20] pf_base_i = {32'h1, 12'h0};
   logic [31:20] pf_limit_lo_i = 12'h00f;
   logic [15:12] io_base_lo_i = 4'h1, io_limit_lo_i = 4'hc;
   logic pri_valid_i = 1'b0, pri_is_io_i = 1'b0, sec_valid_i, sec_is_io_i, sec_par_err_i;
   logic [63:0] pri_addr_i = 64'h0, sec_addr_i, a;
   logic sec_a_error_pin_n_i, sec_b_error_pin_n_i, down_fwd_o, down_done_o, up_fwd_o;
   logic up_done_o, pri_error_req_o, sec_par_report_o, m_rx, m_pe;
   logic e_chk, e_dd, e_df, e_ud, e_uf, e_err, e_par;
   logic [2:0] m_ctl;
   logic [1:0] m_run;
   logic [7:0] offs[6] = '{8'h2c, 8'h30, 8'h34, 8'h3c, 8'h1c, 8'h40};
   logic [63:0] edges[8] = '{64'hfff, 64'h1000, 64'hcfff, 64'hd000, 64'hffff_ffff,
      64'h1_0000_0000, 64'h1_00ff_ffff, 64'h1_0100_0000};
   int fail_count = 0, n_tests = 0, seed = 87826, cyc = 0;
   bwd_ctrl dut_u (.clk_i, .nrst_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_be_i,
      .cfg_wdata_i, .cfg_rdata_o, .pf_base_i, .pf_limit_lo_i, .io_base_lo_i, .io_limit_lo_i,
      .pri_valid_i, .pri_is_io_i, .pri_addr_i, .down_fwd_o, .down_done_o, .sec_valid_i,
      .sec_is_io_i, .sec_addr_i, .up_fwd_o, .up_done_o, .sec_a_error_pin_n_i,
      .sec_b_error_pin_n_i, .sec_par_err_i, .pri_error_req_o, .sec_par_report_o);
   bwd_sec_agent sec_u (.clk_i, .sec_valid_o(sec_valid_i), .sec_is_io_o(sec_is_io_i),
      .sec_addr_o(sec_addr_i), .sec_a_n_o(sec_a_error_pin_n_i),
      .sec_b_n_o(sec_b_error_pin_n_i), .par_o(sec_par_err_i));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   // ****************************************************************
   // Reference model.
   // ****************************************************************
   // Inclusive windows; with bit 18 set, alias addresses are never sent down, always up.
   function automatic logic fwd(input logic up, input logic io, input logic [63:0] x);
      logic in_w;
      logic al;
      if (io) in_w = x[31:0] >= {m_io[15:0], io_base_lo_i, 12'h0}
         && x[31:0] <= {m_io[31:16], io_limit_lo_i, 12'hfff};
      else in_w = x >= {pf_base_i, 20'h0} && x <= {m_pfh, pf_limit_lo_i, 20'hfffff};
      al = io && m_ctl[2] && x[31:16] == 16'h0 && x[9:8] != 2'h0;
      return up ? (!in_w || al) : (in_w && !al);
   endfunction : fwd
   function automatic logic [31:0] rd_val(input logic [7:0] ad);
      case (ad)
         OFS_PF_LIMIT_HIGH: return m_pfh;
         OFS_IO_HIGH: return m_io;
         OFS_CAP_PTR: return 32'h0000_00b0;
         OFS_BRIDGE_CTRL: return {13'h0, m_ctl, 16'h0};
         OFS_SEC_STATUS: return {m_pe, m_rx, 30'h0};
         default: return 32'h0;
      endcase
   endfunction : rd_val
   // Flag sets come last so that a set beats a write-one clear.
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {m_run, m_pfh, m_io, m_ctl, m_rx, m_pe} <= '0;
         {e_chk, e_dd, e_df, e_ud, e_uf, e_err, e_par} <= '0;
      end else begin
         m_run <= {m_run[0], 1'b1};
         if (m_run[1]) begin
            e_chk <= cfg_rd_i;
            e_rd <= rd_val(cfg_addr_i);
            {e_dd, e_ud} <= {pri_valid_i, sec_valid_i};
            e_df <= pri_valid_i && fwd(1'b0, pri_is_io_i, pri_addr_i);
            e_uf <= sec_valid_i && fwd(1'b1, sec_is_io_i, sec_addr_i);
            e_err <= m_ctl[1] && !(sec_a_error_pin_n_i && sec_b_error_pin_n_i);
            e_par <= m_ctl[0] && sec_par_err_i;
            for (int i = 0; i < 4; i++) begin
               if (cfg_wr_i && cfg_be_i[i] && cfg_addr_i == OFS_PF_LIMIT_HIGH)
                  m_pfh[8*i+:8] <= cfg_wdata_i[8*i+:8];
               if (cfg_wr_i && cfg_be_i[i] && cfg_addr_i == OFS_IO_HIGH)
                  m_io[8*i+:8] <= cfg_wdata_i[8*i+:8];
            end
            if (cfg_wr_i && cfg_be_i[2] && cfg_addr_i == OFS_BRIDGE_CTRL)
               m_ctl <= cfg_wdata_i[18:16];
            if (cfg_wr_i && cfg_be_i[3] && cfg_addr_i == OFS_SEC_STATUS)
               {m_pe, m_rx} <= {m_pe, m_rx} & ~cfg_wdata_i[31:30];
            if (!(sec_a_error_pin_n_i && sec_b_error_pin_n_i)) m_rx <= 1'b1;
            if (m_ctl[0] && sec_par_err_i) m_pe <= 1'b1;
         end
      end
   end
   // ****************************************************************
   // Comparison, bus tasks and closing.
   // ****************************************************************
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp
   always @(negedge clk_i) begin
      if (e_chk) cmp(cfg_rdata_o, e_rd, "read data");
      if (cyc > 2) cmp(32'({down_done_o, down_fwd_o, up_done_o, up_fwd_o}),
         32'({e_dd, e_df, e_ud, e_uf}), "decode");
      if (cyc > 2) cmp(32'({pri_error_req_o, sec_par_report_o}), 32'({e_err, e_par}),
         "errors");
   end
   task automatic wr(input logic [7:0] ad, input logic [3:0] be, input logic [31:0] d);
      @(negedge clk_i);
      {cfg_wr_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = {1'b1, ad, be, d};
      @(negedge clk_i);
      cfg_wr_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] ad);
      @(negedge clk_i);
      {cfg_rd_i, cfg_addr_i} = {1'b1, ad};
      @(negedge clk_i);
      cfg_rd_i = 1'b0;
   endtask : rd
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   // A hang is cut short well beyond the few hundred cycles expected.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (20) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      foreach (offs[i]) rd(offs[i]);
      wr(8'h34, 4'hf, 32'hffff_ffff);
      rd(8'h34);
      for (int i = 0; i < 8; i++) begin
         wr(i[0] ? 8'h30 : 8'h2c, 4'($random(seed)), $random(seed));
         rd(i[0] ? 8'h30 : 8'h2c);
      end
      wr(8'h2c, 4'hf, 32'h1);
      wr(8'h30, 4'hf, 32'h0);
      // Back-to-back decodes on both sides, ISA blocking off then on.
      for (int m = 0; m < 2; m++) begin
         wr(8'h3c, 4'h4, {13'h0, m[0], 18'h0});
         for (int i = 0; i < 48; i++) begin
            a = i < 8 ? edges[i] : {31'h0, 1'($random(seed)), 8'h0, 24'($random(seed))};
            @(negedge clk_i);
            pri_valid_i = 1'b1;
            pri_is_io_i = i < 4 || (i > 7 && i[3]);
            pri_addr_i = pri_is_io_i && i > 7 ? {47'h0, a[32] & a[23], a[15:0]} : a;
            sec_u.req(!pri_is_io_i, pri_is_io_i ? a : {48'h0, a[15:0]});
         end
         @(negedge clk_i);
         pri_valid_i = 1'b0;
         sec_u.idle();
      end
      sec_u.perr();
      sec_u.serr(1'b0, 3);
      rd(8'h1c);
      wr(8'h1c, 4'h8, 32'hc000_0000);
      wr(8'h3c, 4'h4, 32'h0007_0000);
      rd(8'h3c);
      fork
         sec_u.serr(1'b1, 6);
         begin
            repeat (2) @(negedge clk_i);
            rd(8'h1c);
            wr(8'h1c, 4'h8, 32'h4000_0000);
         end
      join
      sec_u.perr();
      rd(8'h1c);
      wr(8'h1c, 4'h8, 32'hc000_0000);
      rd(8'h1c);
      print_verdict();
   end
endmodule : bwd_ctrl_tb
